// [src/pmurs_pkg.sv]
// What this block does
// R1: First profile chains rails with listed delays
// R2: First profile: pushbutton press launches startup
// R3: Pushbutton released before hold and enable: shutdown
// R4: First profile: enable rise launches same startup
// R5: First profile: rails 4,5,6,12 need software
// R6: First profile: three turn-off events
// R7: Bucks default forced PWM, software may change
// R8: First profile: reset follows rail nine, 40ms
// R9: First profile: voltage select by software only
// R10: Unused general outputs start off, software enables; outputs one and two stay masked off in both profiles
// R11: Third general output toggles 256Hz, 50%; the second profile masks this output off, so it stays low there
// R12: Outputs four to six: 0.25Hz, 6.25% high; the second profile masks output five off, so only four and six pulse there
// R13: Second profile starts on input power alone
// R14: Second profile: rail seven on power, thirteen off
// R15: Second profile: software or 10s press off
// R16: Second profile: reset follows rail twelve, 40ms
// R17: Second profile: gp_pin_two selects rail one voltage
// R18: Second profile: gp_pin_three triggers rails 3,5,6
// R19: Second profile: rail eleven needs pins three and five
// R20: Processor raises pin five after reset release
// R21: Second profile: watchdog off until software enables
// R22: Chain delay starts at trigger rail good
package pmurs_pkg;

  // ==========================================================
  // Sequencer states
  typedef enum logic [1:0] {PMURS_OFF, PMURS_PB_WAIT, PMURS_ON, PMURS_HALT} pmurs_state_e;

  // ==========================================================
  // Control pins, sampled as one group
  typedef struct packed {
    logic pb_n;
    logic pen;
    logic phold;
    logic g1;
    logic g2;
    logic g3;
    logic g5;
    logic uvlo;
    logic prof_b;
  } pmurs_pins_s;

  localparam pmurs_pins_s PMURS_PIN_RST = '{pb_n: 1'b1, default: 1'b0};

  // ==========================================================
  // Timing
  localparam int PMURS_CLK_MHZ       = 25;
  localparam int PMURS_CLK_HZ        = PMURS_CLK_MHZ * 1000000;
  localparam int PMURS_DLY_SHORT_US  = 500;
  localparam int PMURS_DLY_MID_US    = 1000;
  localparam int PMURS_DLY_LONG_US   = 2000;
  localparam int PMURS_RST_DLY_MS    = 40;
  localparam int PMURS_LONG_PRESS_S  = 10;
  localparam int PMURS_TONE_HZ       = 256;
  localparam int PMURS_SLOW_FREQ_CHZ = 25;   // 0.25 Hz in hundredths
  localparam int PMURS_SLOW_DUTY_BP  = 625;  // 6.25 % in hundredths of a percent
  localparam int PMURS_DLY_SHORT_CYC = PMURS_DLY_SHORT_US * PMURS_CLK_MHZ;
  localparam int PMURS_DLY_MID_CYC   = PMURS_DLY_MID_US * PMURS_CLK_MHZ;
  localparam int PMURS_DLY_LONG_CYC  = PMURS_DLY_LONG_US * PMURS_CLK_MHZ;
  localparam int PMURS_RST_DLY_CYC   = PMURS_RST_DLY_MS * 1000 * PMURS_CLK_MHZ;
  localparam int PMURS_LONG_CYC      = PMURS_LONG_PRESS_S * PMURS_CLK_HZ;
  localparam int PMURS_TONE_HALF_CYC = PMURS_CLK_HZ / (2 * PMURS_TONE_HZ);
  localparam int PMURS_SLOW_CYC      = PMURS_CLK_HZ / PMURS_SLOW_FREQ_CHZ * 100;
  localparam int PMURS_SLOW_HIGH_CYC = PMURS_SLOW_CYC / 10000 * PMURS_SLOW_DUTY_BP;
  localparam logic [1:0] PMURS_STRAP_DONE = 2'h3;

  // ==========================================================
  // Rail trigger sources: 0..12 are rails, then pins and fixed ones
  localparam logic [4:0] PMURS_SRC_GP1    = 5'h0D;
  localparam logic [4:0] PMURS_SRC_GP3    = 5'h0E;  // this and above follow level
  localparam logic [4:0] PMURS_SRC_GP35   = 5'h0F;
  localparam logic [4:0] PMURS_SRC_UVLO   = 5'h10;
  localparam logic [4:0] PMURS_SRC_SW     = 5'h11;
  localparam logic [4:0] PMURS_SRC_ALWAYS = 5'h12;
  localparam logic [4:0] PMURS_SRC_NONE   = 5'h13;

  // Delay codes: none, short, mid, long
  localparam logic [12:0][4:0] PMURS_SRC_A = {5'h12, 5'h11, 5'h00, 5'h07, 5'h07, 5'h02, 5'h01,
                                              5'h11, 5'h11, 5'h11, 5'h0A, 5'h0D, 5'h06};
  localparam logic [12:0][1:0] PMURS_DLY_A = {2'h0, 2'h0, 2'h1, 2'h1, 2'h2, 2'h1, 2'h1,
                                              2'h0, 2'h0, 2'h0, 2'h1, 2'h1, 2'h0};
  localparam logic [12:0][4:0] PMURS_SRC_B = {5'h13, 5'h00, 5'h0F, 5'h00, 5'h01, 5'h08, 5'h10,
                                              5'h0E, 5'h0E, 5'h02, 5'h0E, 5'h0D, 5'h02};
  localparam logic [12:0][1:0] PMURS_DLY_B = {2'h0, 2'h3, 2'h0, 2'h3, 2'h3, 2'h3, 2'h0,
                                              2'h0, 2'h0, 2'h3, 2'h0, 2'h3, 2'h3};

  // Reset gate rail per profile, general outputs usable per profile
  localparam int         PMURS_RST_RAIL_A = 8;
  localparam int         PMURS_RST_RAIL_B = 11;
  localparam logic [5:0] PMURS_GPO_MASK_A = 6'h3C;
  localparam logic [5:0] PMURS_GPO_MASK_B = 6'h28;

  // ==========================================================
  // Whole sequencer state
  typedef struct packed {
    pmurs_state_e     st;
    pmurs_pins_s      s1;
    pmurs_pins_s      s2;
    logic [12:0]      pg1;
    logic [12:0]      pg2;
    logic [1:0]       strap_cnt;
    logic             prof_b;
    logic             pen_d;
    logic             pb_d;
    logic [12:0]      rail_on;
    logic [12:0][15:0] dly_cnt;
    logic [19:0]      rst_cnt;
    logic             rst_n;
    logic [27:0]      pb_cnt;
    logic [15:0]      tone_cnt;
    logic             tone;
    logic [26:0]      slow_cnt;
    logic [5:0]       gpo;
    logic [3:0]       psave;
    logic             vsel;
    logic             wdog;
  } pmurs_state_s;

  localparam pmurs_state_s PMURS_STATE_RST = '{st: PMURS_OFF, s1: PMURS_PIN_RST, s2: PMURS_PIN_RST,
                                               pb_d: 1'b1, default: '0};

endpackage : pmurs_pkg

// [src/pmurs_rail_sequencer.sv]
`timescale 1ns/100ps
module pmurs_rail_sequencer import pmurs_pkg::*; #(
  parameter int DLY_SHORT_CYC = PMURS_DLY_SHORT_CYC,
  parameter int DLY_MID_CYC   = PMURS_DLY_MID_CYC,
  parameter int DLY_LONG_CYC  = PMURS_DLY_LONG_CYC,
  parameter int RST_DLY_CYC   = PMURS_RST_DLY_CYC,
  parameter int LONG_CYC      = PMURS_LONG_CYC,
  parameter int TONE_HALF_CYC = PMURS_TONE_HALF_CYC,
  parameter int SLOW_CYC      = PMURS_SLOW_CYC,
  parameter int SLOW_HIGH_CYC = PMURS_SLOW_HIGH_CYC
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // Control pins from the board
  input  wire logic        pushbutton_in_n,
  input  wire logic        power_enable_in,
  input  wire logic        power_hold_in,
  input  wire logic        gp_pin_one,
  input  wire logic        gp_pin_two,
  input  wire logic        gp_pin_three,
  input  wire logic        gp_pin_five,
  input  wire logic        input_power_ok,
  input  wire logic        profile_b_strap,
  // Regulation status from the rails
  input  wire logic [12:0] rail_good,
  // Software control bits
  input  wire logic [12:0] sw_rail_en,
  input  wire logic        sw_turn_off,
  input  wire logic [3:0]  sw_buck_psave,
  input  wire logic        sw_volt_sel,
  input  wire logic [5:0]  sw_gpo_en,
  input  wire logic        sw_wdog_en,
  // Outputs
  output logic      [12:0] rail_en,
  output logic             reset_out_n,
  output logic      [5:0]  gpo_out,
  output logic      [3:0]  buck_psave,
  output logic             rail_one_vsel,
  output logic             wdog_en,
  output pmurs_state_e     seq_state
);

  pmurs_state_s q;
  pmurs_state_s d;
  pmurs_pins_s  pins_raw;
  logic         long_press;
  logic         rst_ok;
  logic [12:0]  trig;

  // ==========================================================
  // Delay code to cycles
  function automatic logic [15:0] dly_cycles(input logic [1:0] code);
    unique case (code)
      2'h0: dly_cycles = 16'h0000;
      2'h1: dly_cycles = 16'(DLY_SHORT_CYC);
      2'h2: dly_cycles = 16'(DLY_MID_CYC);
      2'h3: dly_cycles = 16'(DLY_LONG_CYC);
    endcase
  endfunction : dly_cycles

  // Trigger level of one source
  function automatic logic src_level(input logic [4:0] src, input pmurs_state_s s, input logic sw);
    if (src < PMURS_SRC_GP1) src_level = s.rail_on[src[3:0]] && s.pg2[src[3:0]];  // R22
    else begin
      unique case (src)
        PMURS_SRC_GP1:    src_level = s.s2.g1;
        PMURS_SRC_GP3:    src_level = s.s2.g3;
        PMURS_SRC_GP35:   src_level = s.s2.g3 && s.s2.g5;  // R19
        PMURS_SRC_UVLO:   src_level = s.s2.uvlo;
        PMURS_SRC_SW:     src_level = sw;
        PMURS_SRC_ALWAYS: src_level = s.s2.uvlo;
        default:          src_level = 1'b0;
      endcase
    end
  endfunction : src_level

  assign pins_raw = '{pb_n: pushbutton_in_n, pen: power_enable_in, phold: power_hold_in, g1: gp_pin_one,
                      g2: gp_pin_two, g3: gp_pin_three, g5: gp_pin_five, uvlo: input_power_ok,
                      prof_b: profile_b_strap};

  // ==========================================================
  // Next-state logic
  always_comb begin
    logic [4:0] src;
    logic [1:0] dcode;
    logic       gate;
    logic       rr;
    src   = 5'h00;
    dcode = 2'h0;
    gate  = 1'b0;
    rr    = 1'b0;
    d     = q;
    trig  = '0;
    // Two-stage sampling of board levels
    d.s1  = pins_raw;
    d.s2  = q.s1;
    d.pg1 = rail_good;
    d.pg2 = q.pg1;
    d.pen_d = q.s2.pen;
    d.pb_d  = q.s2.pb_n;
    // Profile strap caught after reset release
    if (q.strap_cnt != PMURS_STRAP_DONE) begin
      d.strap_cnt = q.strap_cnt + 2'h1;
      d.prof_b    = q.s2.prof_b;
    end
    // Pushbutton hold time
    if (q.s2.pb_n) d.pb_cnt = '0;
    else if (q.pb_cnt != 28'(LONG_CYC)) d.pb_cnt = q.pb_cnt + 28'h1;
    long_press = (q.pb_cnt == 28'(LONG_CYC));

    // Power state machine
    unique case (q.st)
      PMURS_OFF: begin
        if (q.strap_cnt == PMURS_STRAP_DONE && q.s2.uvlo) begin
          if (q.prof_b) d.st = PMURS_ON;                                      // R13
          else if (q.pb_d && !q.s2.pb_n) d.st = PMURS_PB_WAIT;                // R2
          else if (!q.pen_d && q.s2.pen && q.s2.pb_n) d.st = PMURS_ON;        // R4
        end
      end
      PMURS_PB_WAIT: begin
        if (q.s2.pen && q.s2.phold) d.st = PMURS_ON;
        else if (q.s2.pb_n) d.st = PMURS_OFF;                                 // R3
      end
      PMURS_ON: begin
        if (q.prof_b) begin
          if (sw_turn_off || long_press) d.st = PMURS_HALT;                   // R15
        end else if (sw_turn_off || long_press || (!q.s2.pen && !q.s2.phold)) begin
          d.st = PMURS_OFF;                                                   // R6
        end
      end
      PMURS_HALT: if (!q.s2.uvlo) d.st = PMURS_OFF;
    endcase
    if (!q.s2.uvlo) d.st = PMURS_OFF;

    // Rail enables: chained and pin-one rails latch, other pin and software rails follow
    for (int i = 0; i < 13; i++) begin
      src     = q.prof_b ? PMURS_SRC_B[i] : PMURS_SRC_A[i];                   // R1 R14 R18
      dcode   = q.prof_b ? PMURS_DLY_B[i] : PMURS_DLY_A[i];
      trig[i] = src_level(src, q, sw_rail_en[i]);                             // R5
      // Rails wait for the strap, else rail thirteen blips in profile B
      gate    = (q.strap_cnt == PMURS_STRAP_DONE) && ((q.st == PMURS_ON) || (src == PMURS_SRC_ALWAYS && q.s2.uvlo));
      if (!gate || (src >= PMURS_SRC_GP3 && !trig[i])) begin
        d.rail_on[i] = 1'b0;
        d.dly_cnt[i] = '0;
      end else if (trig[i] && !q.rail_on[i]) begin
        if (q.dly_cnt[i] >= dly_cycles(dcode)) d.rail_on[i] = 1'b1;         // R1 R22
        else d.dly_cnt[i] = q.dly_cnt[i] + 16'h0001;
      end
    end

    // Reset output after gate rail has been good long enough
    rr     = q.prof_b ? (q.rail_on[PMURS_RST_RAIL_B] && q.pg2[PMURS_RST_RAIL_B])
                      : (q.rail_on[PMURS_RST_RAIL_A] && q.pg2[PMURS_RST_RAIL_A]);
    rst_ok = rr && (q.st == PMURS_ON);
    if (!rst_ok) begin
      d.rst_cnt = '0;
      d.rst_n   = 1'b0;
    end else if (q.rst_cnt == 20'(RST_DLY_CYC)) d.rst_n = 1'b1;              // R8 R16
    else d.rst_cnt = q.rst_cnt + 20'h00001;

    // Square wave for the third output
    if (!sw_gpo_en[2]) begin
      d.tone_cnt = '0;
      d.tone     = 1'b0;
    end else if (q.tone_cnt == 16'(TONE_HALF_CYC - 1)) begin
      d.tone_cnt = '0;
      d.tone     = ~q.tone;                                                   // R11
    end else d.tone_cnt = q.tone_cnt + 16'h0001;

    // Slow pulse period for outputs four to six
    if (sw_gpo_en[5:3] == 3'h0 || q.slow_cnt == 27'(SLOW_CYC - 1)) d.slow_cnt = '0;
    else d.slow_cnt = q.slow_cnt + 27'h0000001;

    // General outputs, masked to those usable in this profile
    d.gpo[1:0] = sw_gpo_en[1:0];                                              // R10
    d.gpo[2]   = sw_gpo_en[2] && q.tone;
    for (int k = 3; k < 6; k++) d.gpo[k] = sw_gpo_en[k] && (q.slow_cnt < 27'(SLOW_HIGH_CYC));  // R12
    d.gpo = d.gpo & (q.prof_b ? PMURS_GPO_MASK_B : PMURS_GPO_MASK_A);

    // Mode bits
    d.psave = sw_buck_psave;                                                  // R7
    d.vsel  = q.prof_b ? q.s2.g2 : sw_volt_sel;                               // R9 R17
    d.wdog  = sw_wdog_en;                                                     // R21
  end

  // ==========================================================
  // State register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) q <= PMURS_STATE_RST;
    else q <= d;
  end

  // Outputs straight from flip-flops
  assign rail_en       = q.rail_on;
  assign reset_out_n   = q.rst_n;
  assign gpo_out       = q.gpo;
  assign buck_psave    = q.psave;
  assign rail_one_vsel = q.vsel;
  assign wdog_en       = q.wdog;
  assign seq_state     = q.st;

  // ==========================================================
  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence pb_press_s;
    q.st == PMURS_OFF && !q.prof_b && q.s2.uvlo && q.strap_cnt == PMURS_STRAP_DONE && q.pb_d && !q.s2.pb_n;
  endsequence
  sequence pb_early_release_s;
    q.st == PMURS_PB_WAIT && q.s2.uvlo && q.s2.pb_n && !(q.s2.pen && q.s2.phold);
  endsequence

  pb_launch_a: assert property (pb_press_s |=> q.st == PMURS_PB_WAIT)  // R2
    else $error("pushbutton press did not launch startup");
  pb_release_a: assert property (pb_press_s ##1 pb_early_release_s |=> q.st == PMURS_OFF)  // R3
    else $error("early pushbutton release did not shut down");
  en_launch_a: assert property (q.st == PMURS_OFF && !q.prof_b && q.s2.uvlo && q.strap_cnt == PMURS_STRAP_DONE
                                && !q.pen_d && q.s2.pen && q.s2.pb_n |=> q.st == PMURS_ON)  // R4
    else $error("enable rise did not launch startup");
  chain_delay_a: assert property (!q.prof_b && $rose(q.rail_on[1]) |-> $past(q.dly_cnt[1]) == 16'(DLY_SHORT_CYC))  // R1
    else $error("rail two came up without its delay");
  sw_rail_a: assert property (!q.prof_b && !sw_rail_en[3] |=> !rail_en[3])  // R5
    else $error("rail four on without software");
  off_a_a: assert property (q.st == PMURS_ON && !q.prof_b && sw_turn_off |=> q.st == PMURS_OFF)  // R6
    else $error("turn-off command ignored");
  psave_a: assert property (##1 $stable(sw_buck_psave) |=> buck_psave == $past(sw_buck_psave, 2))  // R7
    else $error("buck mode does not follow software");
  rst_gate_a: assert property ($rose(reset_out_n) |-> $past(q.rst_cnt) == 20'(RST_DLY_CYC)
                               and $past(rst_ok, 2))  // R8 R16
    else $error("reset released before its delay");
  rst_drop_a: assert property (!rst_ok |=> !reset_out_n)  // R8 R16
    else $error("reset held high without gate rail");
  vsel_a: assert property (!q.prof_b |=> rail_one_vsel == $past(sw_volt_sel))  // R9
    else $error("voltage select not from software");
  vsel_pin_a: assert property (q.prof_b && $past(q.prof_b) |=> rail_one_vsel == $past(q.s2.g2))  // R17
    else $error("voltage select not from pin");
  gpo_off_a: assert property (!sw_gpo_en[3] |=> !gpo_out[3])  // R10
    else $error("general output on while disabled");
  tone_a: assert property (q.gpo[2] != $past(q.gpo[2]) && $past(sw_gpo_en[2], 2) && $past(sw_gpo_en[2])
                           |-> $past(q.tone_cnt, 2) == 16'(TONE_HALF_CYC - 1))  // R11
    else $error("tone toggled off its half period");
  slow_a: assert property (gpo_out[4] |-> $past(q.slow_cnt) < 27'(SLOW_HIGH_CYC))  // R12
    else $error("slow pulse high too long");
  auto_on_a: assert property (q.st == PMURS_OFF && q.prof_b && q.s2.uvlo && q.strap_cnt == PMURS_STRAP_DONE
                              |=> q.st == PMURS_ON)  // R13
    else $error("second profile did not start on power");
  rail13_a: assert property (q.prof_b |-> !rail_en[12])  // R14
    else $error("rail thirteen on in second profile");
  off_b_a: assert property (q.st == PMURS_ON && q.prof_b && q.s2.uvlo && long_press |=> q.st == PMURS_HALT)  // R15
    else $error("long press did not turn off");
  gp3_rail_a: assert property (q.prof_b && q.st == PMURS_ON && $past(q.st) == PMURS_ON && q.s2.g3 && !q.rail_on[2]
                               |=> rail_en[2])  // R18
    else $error("rail three did not follow pin three");
  and_gate_a: assert property (q.prof_b && rail_en[10] |-> $past(q.s2.g3 && q.s2.g5))  // R19
    else $error("rail eleven on without both pins");
  wdog_a: assert property (!sw_wdog_en |=> !wdog_en)  // R21
    else $error("watchdog enabled without software");
  pg_wait_a: assert property (!q.prof_b && !q.pg2[1] && !q.rail_on[6] |=> !rail_en[6])  // R22
    else $error("rail seven started before rail two good");

  // ==========================================================
  // Checks on start and turn-off paths, rail gating and watchdog

  // Held start completes once hold and enable arrive
  hold_on_a: assert property (q.st == PMURS_PB_WAIT && q.s2.uvlo && q.s2.pen && q.s2.phold  // R3
                              |=> q.st == PMURS_ON)
    else $error("held start did not complete");

  // Hold and enable both low stop profile A
  pen_off_a: assert property (q.st == PMURS_ON && !q.prof_b && !q.s2.pen && !q.s2.phold |=> q.st == PMURS_OFF)  // R6
    else $error("hold and enable low ignored");

  // Long hold stops profile A too
  long_off_a: assert property (q.st == PMURS_ON && !q.prof_b && long_press |=> q.st == PMURS_OFF)  // R6
    else $error("long hold did not shut down");

  // Profile B stays down until power cycles
  halt_stay_a: assert property (q.st == PMURS_HALT && q.s2.uvlo |=> q.st == PMURS_HALT)  // R15
    else $error("halted device restarted");

  // Profile B rails only in run state
  rails_off_b_a: assert property (q.prof_b && q.st != PMURS_ON |=> rail_en == 13'h0000)  // R15
    else $error("rail on outside run state");

  // No rail comes on before the profile is known
  strap_wait_a: assert property (q.strap_cnt != PMURS_STRAP_DONE |=> rail_en == 13'h0000)  // R14
    else $error("rail on before profile known");

  // Rail thirteen follows power in profile A
  always_on_a: assert property (!q.prof_b && q.strap_cnt == PMURS_STRAP_DONE && q.s2.uvlo |=> rail_en[12])  // R1
    else $error("rail thirteen off with power");

  // Software rail comes up when asked
  sw_on_a: assert property (!q.prof_b && q.st == PMURS_ON && sw_rail_en[11] |=> rail_en[11])  // R5
    else $error("rail twelve ignored software");

  // Pin-three rails drop with their pin
  gp3_drop_a: assert property (q.prof_b && !q.s2.g3 |=> !rail_en[2])  // R18
    else $error("rail three on without pin three");

  // Watchdog follows software enable
  wdog_on_a: assert property (sw_wdog_en |=> wdog_en)  // R21
    else $error("watchdog enable ignored");

endmodule : pmurs_rail_sequencer

// [dv/pmurs_cpu_model.sv]
`timescale 1ns/100ps
module pmurs_cpu_model import pmurs_pkg::*; #(
  parameter int SS_CYC = 3
) (
  // Clock
  input  wire logic         clk,
  // Block outputs seen on the board
  input  wire logic  [12:0] rail_en,
  input  wire logic         reset_out_n,
  input  wire pmurs_state_e seq_state,
  // Commands from the bench
  input  wire logic         ack_pb,
  input  wire logic         pen_req,
  input  wire logic         g5_req,
  // Lines driven back to the block
  output logic       [12:0] rail_good,
  output logic              power_enable_in,
  output logic              power_hold_in,
  output logic              gp_pin_five
);
  int   ss_cnt [13];
  logic hold_lat;

  // ==========================================================
  // Rails report good after soft-start, drop at once when disabled
  always @(negedge clk) begin
    for (int i = 0; i < 13; i++) begin
      if (rail_en[i] !== 1'b1) ss_cnt[i] = 0;
      else if (ss_cnt[i] < SS_CYC) ss_cnt[i]++;
      rail_good[i] <= (ss_cnt[i] == SS_CYC);
    end
  end

  // ==========================================================
  // Processor: hold and enable are wired together
  always @(negedge clk) begin
    if (!ack_pb) hold_lat = 1'b0;
    else if (seq_state === PMURS_PB_WAIT) hold_lat = 1'b1;
    power_enable_in <= hold_lat | pen_req;
    power_hold_in   <= hold_lat | pen_req;
    gp_pin_five     <= g5_req && (reset_out_n === 1'b1);
  end
endmodule : pmurs_cpu_model

// [dv/pmurs_rail_sequencer_test.sv]
`timescale 1ns/100ps
module pmurs_rail_sequencer_test import pmurs_pkg::*;;
  localparam int SS = 3;
  localparam int D_S = 5;
  localparam int D_M = 10;
  localparam int LONG = 40;
  localparam int TONE_H = 4;
  localparam int SLOW = 32;
  localparam int SLOW_HI = 2;
  localparam int D_L = 20;
  localparam int RST_D = 50;
  localparam int LIMIT = 5000;

  logic clk, rst_n, pb_n, gp1, gp2, gp3, g5, pwr_ok, strap, pen, hold;
  logic [12:0] rail_good, sw_rail_en, rail_en, prev_en;
  logic sw_turn_off, sw_volt_sel, sw_wdog_en, reset_out_n, rail_one_vsel, wdog_en;
  logic [3:0]  sw_buck_psave, buck_psave;
  logic [5:0]  sw_gpo_en, gpo_out;
  logic        ack_pb, pen_req, g5_req;
  pmurs_state_e seq_state;
  int          cyc, num_errors, checks_done, t_g1, n;
  int          on_t [13];
  int          hi [6];
  int          exp_hi [6] = '{0, 0, 32, 4, 4, 4};

  pmurs_rail_sequencer #(.DLY_SHORT_CYC(D_S), .DLY_MID_CYC(D_M), .DLY_LONG_CYC(D_L), .RST_DLY_CYC(RST_D),
    .LONG_CYC(LONG), .TONE_HALF_CYC(TONE_H), .SLOW_CYC(SLOW), .SLOW_HIGH_CYC(SLOW_HI)) pmurs_rail_sequencer_i (
    .clk(clk), .rst_n(rst_n), .pushbutton_in_n(pb_n), .power_enable_in(pen), .power_hold_in(hold),
    .gp_pin_one(gp1), .gp_pin_two(gp2), .gp_pin_three(gp3), .gp_pin_five(g5), .input_power_ok(pwr_ok),
    .profile_b_strap(strap), .rail_good(rail_good), .sw_rail_en(sw_rail_en), .sw_turn_off(sw_turn_off),
    .sw_buck_psave(sw_buck_psave), .sw_volt_sel(sw_volt_sel), .sw_gpo_en(sw_gpo_en), .sw_wdog_en(sw_wdog_en),
    .rail_en(rail_en), .reset_out_n(reset_out_n), .gpo_out(gpo_out), .buck_psave(buck_psave),
    .rail_one_vsel(rail_one_vsel), .wdog_en(wdog_en), .seq_state(seq_state));

  pmurs_cpu_model #(.SS_CYC(SS)) pmurs_cpu_model_i (
    .clk(clk), .rail_en(rail_en), .reset_out_n(reset_out_n), .seq_state(seq_state), .ack_pb(ack_pb),
    .pen_req(pen_req), .g5_req(g5_req), .rail_good(rail_good), .power_enable_in(pen),
    .power_hold_in(hold), .gp_pin_five(g5));

  // ==========================================================
  // Clock, rail rise times and timeout
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    prev_en <= rail_en;
    for (int i = 0; i < 13; i++) if (rail_en[i] === 1'b1 && prev_en[i] !== 1'b1) on_t[i] <= cyc;
    if (cyc == LIMIT) begin
      num_errors++;
      end_of_test();
    end
  end

  // ==========================================================
  // Helpers
  task automatic check(input logic [15:0] seen, input logic [15:0] expv, input string what);
    checks_done++;
    if (seen !== expv) begin
      num_errors++;
      $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, what, seen, expv);
    end
  endtask : check

  task automatic ticks(input int k);
    repeat (k) @(negedge clk);
  endtask : ticks

  function automatic logic in_win(input int gap, input int lo);
    return gap >= lo && gap <= lo + 8;
  endfunction : in_win

  task automatic wait_rail(input int i);
    for (int k = 0; k < 400 && rail_en[i] !== 1'b1; k++) @(negedge clk);
    check(16'(rail_en[i]), 16'h0001, "rail enable missing");
    @(negedge clk);  // Let the rise time be logged
  endtask : wait_rail

  task automatic wait_state(input pmurs_state_e s);
    for (int k = 0; k < 20 && seq_state !== s; k++) @(negedge clk);
    check(16'(seq_state), 16'(s), "sequencer state");
  endtask : wait_state

  task automatic reset_after(input int r);
    for (int k = 0; k < 200 && reset_out_n !== 1'b1; k++) @(negedge clk);
    check(16'(in_win(cyc - on_t[r], RST_D + SS)), 16'h0001, "reset release delay");
  endtask : reset_after

  task automatic do_reset(input logic prof);
    rst_n = 1'b0;
    strap = prof;
    ticks(2);
    rst_n = 1'b1;
    ticks(6);
  endtask : do_reset

  task automatic end_of_test();
    $display("Comparisons %0d, mismatches %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : end_of_test

  // ==========================================================
  // Main sequence
  initial begin
    {rst_n, gp1, gp2, gp3, strap, sw_turn_off, sw_volt_sel, sw_wdog_en, ack_pb, pen_req, g5_req} = '0;
    {pb_n, pwr_ok} = 2'b11;
    {sw_rail_en, sw_buck_psave, sw_gpo_en} = '0;
    do_reset(1'b0);
    check(16'(buck_psave), 16'h0000, "power save default");
    check(16'(gpo_out), 16'h0000, "outputs off");
    ack_pb = 1'b1;
    pb_n = 1'b0;
    wait_state(PMURS_PB_WAIT);
    ticks(8);
    pb_n = 1'b1;
    ticks(6);
    check(16'(seq_state), 16'(PMURS_ON), "pushbutton start");
    gp1 = 1'b1;
    t_g1 = cyc;
    wait_rail(8);
    check(16'(reset_out_n), 16'h0000, "reset held");
    check(16'(in_win(on_t[1] - t_g1, D_S)), 16'h0001, "rail two delay");
    check(16'(in_win(on_t[6] - on_t[1], D_S + SS)), 16'h0001, "rail seven delay");
    check(16'(in_win(on_t[0] - on_t[6], SS)), 16'h0001, "rail one delay");
    check(16'(in_win(on_t[8] - on_t[7], D_M + SS)), 16'h0001, "rail nine delay");
    check(16'(rail_en & 13'h0838), 16'h0000, "software rails off");
    reset_after(8);
    sw_rail_en = 13'h0838;
    sw_buck_psave = 4'hA;
    sw_volt_sel = 1'b1;
    gp2 = 1'b0;
    sw_gpo_en = 6'h3F;
    ticks(4);
    check(16'(rail_en & 13'h0838), 16'h0838, "software rails on");
    check(16'(buck_psave), 16'h000A, "power save set");
    check(16'(rail_one_vsel), 16'h0001, "voltage select");
    gp2 = 1'b1;
    sw_volt_sel = 1'b0;
    ticks(4);
    check(16'(rail_one_vsel), 16'h0000, "voltage pin ignored");
    hi = '{default: 0};
    for (int c = 0; c < 64; c++) begin
      @(negedge clk);
      for (int i = 0; i < 6; i++) hi[i] += (gpo_out[i] === 1'b1);
    end
    for (int i = 0; i < 6; i++) check(16'(hi[i]), 16'(exp_hi[i]), "output high count");
    sw_turn_off = 1'b1;
    ticks(3);
    sw_turn_off = 1'b0;
    check(16'(seq_state), 16'(PMURS_OFF), "software off");
    check(16'({rail_en[11:0], reset_out_n}), 16'h0000, "all off");
    {sw_gpo_en, sw_rail_en, ack_pb} = '0;
    $display("Test pushbutton start done");
    pb_n = 1'b0;
    wait_state(PMURS_PB_WAIT);
    pb_n = 1'b1;
    ticks(5);
    check(16'({seq_state, rail_en[11:0]}), 16'h0000, "early release");
    pen_req = 1'b1;
    wait_state(PMURS_ON);
    pen_req = 1'b0;
    wait_state(PMURS_OFF);
    pen_req = 1'b1;
    wait_state(PMURS_ON);
    pb_n = 1'b0;
    ticks(30);
    check(16'(seq_state), 16'(PMURS_ON), "short hold");
    ticks(20);
    check(16'(seq_state), 16'(PMURS_OFF), "long hold");
    pb_n = 1'b1;
    pen_req = 1'b0;
    $display("Test enable path done");
    gp1 = 1'b0;
    do_reset(1'b1);
    wait_state(PMURS_ON);
    ticks(2);
    check(16'(rail_en & 13'h1040), 16'h0040, "rails seven and thirteen");
    check(16'(wdog_en), 16'h0000, "watchdog off");
    sw_wdog_en = 1'b1;
    gp2 = 1'b0;
    ticks(4);
    check(16'(wdog_en), 16'h0001, "watchdog on");
    check(16'(rail_one_vsel), 16'h0000, "high voltage");
    gp2 = 1'b1;
    gp3 = 1'b1;
    ticks(4);
    check(16'(rail_one_vsel), 16'h0001, "low voltage");
    check(16'(rail_en & 13'h0434), 16'h0034, "pin rails");
    wait_rail(0);
    check(16'(in_win(on_t[0] - on_t[2], D_L + SS)), 16'h0001, "rail one after three");
    wait_rail(11);
    check(16'(reset_out_n), 16'h0000, "reset held");
    reset_after(11);
    g5_req = 1'b1;
    ticks(5);
    check(16'(rail_en[10]), 16'h0001, "rail eleven on");
    gp3 = 1'b0;
    ticks(4);
    check(16'(rail_en[10]), 16'h0000, "rail eleven off");
    pb_n = 1'b0;
    ticks(30);
    check(16'(seq_state), 16'(PMURS_ON), "short hold");
    ticks(20);
    check(16'({seq_state, rail_en}), 16'({PMURS_HALT, 13'h0000}), "long hold");
    pwr_ok = 1'b0;
    wait_state(PMURS_OFF);
    $display("Test automatic start done");
    end_of_test();
  end
endmodule : pmurs_rail_sequencer_test
